/* File: mac_unit.sv */
// Notes on behaviour
// - Step multiplies two signed halfwords, accumulates
// - Both pointers advance by two per step
// - Count decrements per step, stops at zero
// - Zero count: no accumulate, no decrement
// - Pointers are next two registers, modulo sixteen
// - High word in AHR, low in ALR
// - Overflow sets flag, operation still continues
// - Overflow flag sticky until software clears
// - Interrupt between steps restarts the instruction
// - Resume uses current count; handler preserves registers
// - Repeat takes two cycles per step plus four
// - Odd pointer raises address error
// - Without multiplier, all multiplies act as nop
// - Signed halfword multiply into ALR, one cycle
// - Unsigned halfword multiply into ALR, one cycle
// - Signed word multiply into AHR:ALR, five cycles
// - Unsigned word multiply into AHR:ALR, five cycles
// - Decode repeat instruction, count register index in bits 7:4
// - Decode unsigned halfword multiply opcode range
// - Decode unsigned word multiply opcode range
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mac_unit_consts.svh"

module mac_unit #(
  parameter int HAS_MULT = 1
) (
  // Clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  RST_I,
  // Instruction issue from decode
  input  wire mac_unit_pkg::issue_t  ISSUE_I,
  input  wire logic                  IRQ_PEND_I,
  output logic                       BUSY_O,
  output mac_unit_pkg::result_t      RESULT_O,
  // Register file ports
  output mac_unit_pkg::rf_idx_t      RD_IDX_O,
  input  wire mac_unit_pkg::rf_val_t RD_VAL_I,
  output mac_unit_pkg::rf_wb_t       WB_O,
  // Data memory port
  output logic                       MEM_REQ_O,
  output logic [31:0]                MEM_ADDR_O,
  input  wire logic [15:0]           MEM_RDATA_I,
  // Accumulator and status
  output logic [31:0]                ALR_O,
  output logic [31:0]                AHR_O,
  output logic                       MULTIPLY_OVERFLOW_FLAG_O,
  // APB slave
  input  wire logic                  PSEL_I,
  input  wire logic                  PENABLE_I,
  input  wire logic                  PWRITE_I,
  input  wire logic [11:0]           PADDR_I,
  input  wire logic [31:0]           PWDATA_I,
  output logic [31:0]                PRDATA_O,
  output logic                       PREADY_O,
  output logic                       PSLVERR_O
);

  if (HAS_MULT != 0 && HAS_MULT != 1) begin : g_chk
    $error("HAS_MULT must be 0 or 1");
  end

  mac_unit_pkg::mac_regs_t r;
  mac_unit_pkg::mac_regs_t next_r;

  function automatic mac_unit_pkg::op_kind_t decode(input logic [15:0] w);
    if (w[15:8] == `OPC_MAC && w[3:0] == `MAC_LOW_BITS) begin
      decode = mac_unit_pkg::OP_MAC;
    end else if (w[15:8] == `OPC_MLTU_H) begin
      decode = mac_unit_pkg::OP_MLTU_H;
    end else if (w[15:8] == `OPC_MLTU_W) begin
      decode = mac_unit_pkg::OP_MLTU_W;
    end else if (w[15:8] == `OPC_MLT_H) begin
      decode = mac_unit_pkg::OP_MLT_H;
    end else if (w[15:8] == `OPC_MLT_W) begin
      decode = mac_unit_pkg::OP_MLT_W;
    end else begin
      decode = mac_unit_pkg::OP_OTHER;
    end
  endfunction

  // Kept as separate branches: a ?: would force unsigned extension
  function automatic logic [31:0] mul_h(input logic [15:0] a,
                                        input logic [15:0] b, input logic sgn);
    if (sgn) begin
      mul_h = $signed(a) * $signed(b);
    end else begin
      mul_h = a * b;
    end
  endfunction

  function automatic logic [63:0] mul_w(input logic [31:0] a,
                                        input logic [31:0] b, input logic sgn);
    if (sgn) begin
      mul_w = $signed(a) * $signed(b);
    end else begin
      mul_w = a * b;
    end
  endfunction

  logic [31:0] step_prod;
  logic [63:0] step_add;
  logic [63:0] acc_sum;
  logic        acc_ovf;
  logic        apb_wr;

  // Second halfword arrives the cycle after its request
  assign step_prod = mul_h(r.d1, MEM_RDATA_I, 1'b1);
  assign step_add  = {{32{step_prod[31]}}, step_prod};
  assign acc_sum   = {r.ahr, r.alr} + step_add;
  assign acc_ovf   = (r.ahr[31] == step_add[63]) && (acc_sum[63] != r.ahr[31]);
  assign apb_wr    = PSEL_I && PENABLE_I && r.pready && PWRITE_I;

  always_comb begin
    next_r         = r;
    next_r.wb.we   = 1'b0;
    next_r.res     = '0;
    next_r.mem_req = 1'b0;
    next_r.pready  = 1'b0;
    next_r.pslverr = 1'b0;
    if (PSEL_I && !PENABLE_I) begin
      next_r.pready = 1'b1;
      next_r.prdata = '0;
      if (PADDR_I == `REG_ALR) begin
        next_r.prdata = r.alr;
      end else if (PADDR_I == `REG_AHR) begin
        next_r.prdata = r.ahr;
      end else if (PADDR_I == `REG_STAT) begin
        next_r.prdata[`STAT_OVF_BIT] = r.ovf;
        next_r.prdata[`STAT_BSY_BIT] = r.busy;
      end else begin
        next_r.pslverr = 1'b1;
      end
    end
    if (apb_wr && PADDR_I == `REG_STAT && PWDATA_I[`STAT_OVF_BIT]) begin
      next_r.ovf = 1'b0;
    end
    // Accumulator writes during an operation would corrupt it
    if (apb_wr && !r.busy && PADDR_I == `REG_ALR) begin
      next_r.alr = PWDATA_I;
    end
    if (apb_wr && !r.busy && PADDR_I == `REG_AHR) begin
      next_r.ahr = PWDATA_I;
    end
    if (r.acc_pend) begin
      next_r.acc_pend = 1'b0;
      {next_r.ahr, next_r.alr} = acc_sum;
      if (acc_ovf) begin
        next_r.ovf = 1'b1;
      end
    end
    case (r.st)
      mac_unit_pkg::ST_IDLE: begin
        if (ISSUE_I.valid) begin
          next_r.op      = decode(ISSUE_I.insn);
          next_r.opa     = ISSUE_I.opa;
          next_r.opb     = ISSUE_I.opb;
          next_r.err     = 1'b0;
          next_r.restart = 1'b0;
          if (next_r.op != mac_unit_pkg::OP_OTHER && HAS_MULT == 0) begin
            next_r.res.done = 1'b1;
          end else if (next_r.op == mac_unit_pkg::OP_MLT_H) begin
            next_r.alr      = mul_h(ISSUE_I.opa[15:0], ISSUE_I.opb[15:0], 1'b1);
            next_r.res.done = 1'b1;
          end else if (next_r.op == mac_unit_pkg::OP_MLTU_H) begin
            next_r.alr      = mul_h(ISSUE_I.opa[15:0], ISSUE_I.opb[15:0], 1'b0);
            next_r.res.done = 1'b1;
          end else if (next_r.op == mac_unit_pkg::OP_MLT_W ||
                       next_r.op == mac_unit_pkg::OP_MLTU_W) begin
            next_r.st   = mac_unit_pkg::ST_WMUL;
            next_r.wcnt = 3'(`WMUL_CYCLES - 2);
            next_r.busy = 1'b1;
          end else if (next_r.op == mac_unit_pkg::OP_MAC) begin
            next_r.st             = mac_unit_pkg::ST_LOAD;
            next_r.busy           = 1'b1;
            next_r.rd_idx.cnt_idx = ISSUE_I.insn[7:4];
            next_r.rd_idx.p1_idx  = ISSUE_I.insn[7:4] + `REG_NEXT1;
            next_r.rd_idx.p2_idx  = ISSUE_I.insn[7:4] + `REG_NEXT2;
          end
        end
      end
      mac_unit_pkg::ST_WMUL: begin
        if (r.wcnt == 3'h0) begin
          {next_r.ahr, next_r.alr} =
            mul_w(r.opa, r.opb, r.op == mac_unit_pkg::OP_MLT_W);
          next_r.res.done = 1'b1;
          next_r.busy     = 1'b0;
          next_r.st       = mac_unit_pkg::ST_IDLE;
        end else begin
          next_r.wcnt = r.wcnt - 3'h1;
        end
      end
      mac_unit_pkg::ST_LOAD: begin
        // Live register values give the remaining count on resume
        next_r.cnt = RD_VAL_I.cnt;
        next_r.p1  = RD_VAL_I.p1;
        next_r.p2  = RD_VAL_I.p2;
        next_r.st  = mac_unit_pkg::ST_CHECK;
      end
      mac_unit_pkg::ST_CHECK: begin
        if (r.cnt == '0) begin
          next_r.st = mac_unit_pkg::ST_DRAIN;
        end else if (r.p1[0] || r.p2[0]) begin
          next_r.err = 1'b1;
          next_r.st  = mac_unit_pkg::ST_DRAIN;
        end else begin
          next_r.mem_req  = 1'b1;
          next_r.mem_addr = r.p1;
          next_r.st       = mac_unit_pkg::ST_RD_A;
        end
      end
      mac_unit_pkg::ST_RD_A: begin
        next_r.mem_req  = 1'b1;
        next_r.mem_addr = r.p2;
        next_r.st       = mac_unit_pkg::ST_RD_B;
      end
      mac_unit_pkg::ST_RD_B: begin
        next_r.d1       = MEM_RDATA_I;
        next_r.acc_pend = 1'b1;
        next_r.cnt      = r.cnt - `CNT_STEP;
        next_r.p1       = r.p1 + `PTR_STEP;
        next_r.p2       = r.p2 + `PTR_STEP;
        next_r.wb.we    = 1'b1;
        next_r.wb.idx   = r.rd_idx;
        next_r.wb.val   = {next_r.cnt, next_r.p1, next_r.p2};
        if (next_r.cnt == '0) begin
          next_r.st = mac_unit_pkg::ST_DRAIN;
        end else if (IRQ_PEND_I) begin
          next_r.restart = 1'b1;
          next_r.st      = mac_unit_pkg::ST_DRAIN;
        end else begin
          next_r.mem_req  = 1'b1;
          next_r.mem_addr = next_r.p1;
          next_r.st       = mac_unit_pkg::ST_RD_A;
        end
      end
      mac_unit_pkg::ST_DRAIN: begin
        next_r.res.done     = 1'b1;
        next_r.res.restart  = r.restart;
        next_r.res.addr_err = r.err;
        next_r.busy         = 1'b0;
        next_r.st           = mac_unit_pkg::ST_IDLE;
      end
      default: begin
        next_r.st = mac_unit_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign BUSY_O                   = r.busy;
  assign RESULT_O                 = r.res;
  assign RD_IDX_O                 = r.rd_idx;
  assign WB_O                     = r.wb;
  assign MEM_REQ_O                = r.mem_req;
  assign MEM_ADDR_O               = r.mem_addr;
  assign ALR_O                    = r.alr;
  assign AHR_O                    = r.ahr;
  assign MULTIPLY_OVERFLOW_FLAG_O = r.ovf;
  assign PRDATA_O                 = r.prdata;
  assign PREADY_O                 = r.pready;
  assign PSLVERR_O                = r.pslverr;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  property p_zero_count;
    (r.st == mac_unit_pkg::ST_CHECK && r.cnt == '0) |=>
      (r.st == mac_unit_pkg::ST_DRAIN && !r.wb.we && $stable({r.ahr, r.alr}));
  endproperty
  a_zero_count: assert property (p_zero_count)
    else $error("zero count changed state");

  property p_ptr_step;
    r.wb.we |-> (r.p1 == $past(r.p1) + `PTR_STEP && r.p2 == $past(r.p2) + `PTR_STEP);
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("pointers not advanced by two");

  property p_cnt_step;
    r.wb.we |-> (r.cnt == $past(r.cnt) - `CNT_STEP && r.wb.val.cnt == r.cnt);
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("count not decremented");

  property p_reg_wrap;
    r.st == mac_unit_pkg::ST_LOAD |->
      (r.rd_idx.p1_idx == r.rd_idx.cnt_idx + `REG_NEXT1 &&
       r.rd_idx.p2_idx == r.rd_idx.cnt_idx + `REG_NEXT2);
  endproperty
  a_reg_wrap: assert property (p_reg_wrap)
    else $error("pointer registers wrong");

  sequence s_one_step;
    r.st == mac_unit_pkg::ST_RD_A ##1 r.st == mac_unit_pkg::ST_RD_B;
  endsequence
  sequence s_finish;
    r.st == mac_unit_pkg::ST_DRAIN ##1 (r.res.done && !r.busy);
  endsequence
  property p_mac_time;
    (r.st == mac_unit_pkg::ST_CHECK && r.cnt == 32'h0000_0001 && !r.p1[0] && !r.p2[0])
      |=> s_one_step ##1 s_finish;
  endproperty
  a_mac_time: assert property (p_mac_time)
    else $error("single step timing wrong");

  property p_word_mul;
    (r.st == mac_unit_pkg::ST_IDLE && ISSUE_I.valid && HAS_MULT == 1 &&
     decode(ISSUE_I.insn) == mac_unit_pkg::OP_MLT_W) |=>
      r.busy [*4] ##1 (r.res.done && {r.ahr, r.alr} == mul_w(r.opa, r.opb, 1'b1));
  endproperty
  a_word_mul: assert property (p_word_mul)
    else $error("word multiply wrong");

  property p_half_mul;
    (r.st == mac_unit_pkg::ST_IDLE && ISSUE_I.valid && HAS_MULT == 1 &&
     decode(ISSUE_I.insn) == mac_unit_pkg::OP_MLT_H) |=>
      (r.res.done && r.alr == mul_h($past(ISSUE_I.opa[15:0]), $past(ISSUE_I.opb[15:0]), 1'b1));
  endproperty
  a_half_mul: assert property (p_half_mul)
    else $error("halfword multiply wrong");

  property p_half_umul;
    (r.st == mac_unit_pkg::ST_IDLE && ISSUE_I.valid && HAS_MULT == 1 &&
     decode(ISSUE_I.insn) == mac_unit_pkg::OP_MLTU_H) |=>
      (r.res.done && r.alr == mul_h($past(ISSUE_I.opa[15:0]), $past(ISSUE_I.opb[15:0]), 1'b0));
  endproperty
  a_half_umul: assert property (p_half_umul)
    else $error("unsigned halfword multiply wrong");

  property p_word_umul;
    (r.st == mac_unit_pkg::ST_IDLE && ISSUE_I.valid && HAS_MULT == 1 &&
     decode(ISSUE_I.insn) == mac_unit_pkg::OP_MLTU_W) |=>
      r.busy [*4] ##1 (r.res.done && {r.ahr, r.alr} == mul_w(r.opa, r.opb, 1'b0));
  endproperty
  a_word_umul: assert property (p_word_umul)
    else $error("unsigned word multiply wrong");

  // Only a core built without the multiplier reaches this
  property p_nop;
    (r.st == mac_unit_pkg::ST_IDLE && ISSUE_I.valid && HAS_MULT == 0 &&
     decode(ISSUE_I.insn) != mac_unit_pkg::OP_OTHER) |=>
      (r.res.done && !r.busy && $stable({r.ahr, r.alr}));
  endproperty
  a_nop: assert property (p_nop)
    else $error("multiply not ignored without multiplier");

  property p_ovf_set;
    (r.acc_pend && acc_ovf) |=> r.ovf;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow not flagged");

  property p_ovf_hold;
    (r.ovf && !(apb_wr && PADDR_I == `REG_STAT && PWDATA_I[`STAT_OVF_BIT])) |=> r.ovf;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow flag dropped");

  property p_irq_stop;
    (r.st == mac_unit_pkg::ST_RD_B && IRQ_PEND_I && r.cnt != `CNT_STEP) |=>
      r.st == mac_unit_pkg::ST_DRAIN ##1 (r.res.done && r.res.restart);
  endproperty
  a_irq_stop: assert property (p_irq_stop)
    else $error("interrupt not taken between steps");

  property p_odd_ptr;
    (r.st == mac_unit_pkg::ST_CHECK && r.cnt != '0 && (r.p1[0] || r.p2[0])) |=>
      !r.mem_req ##1 r.res.addr_err;
  endproperty
  a_odd_ptr: assert property (p_odd_ptr)
    else $error("odd pointer not refused");

endmodule
`default_nettype wire

/* File: mac_unit_consts.svh */
`ifndef MAC_UNIT_CONSTS_SVH
`define MAC_UNIT_CONSTS_SVH

// Opcode high bytes
`define OPC_MAC      8'hB2
`define OPC_MLTU_H   8'hA6
`define OPC_MLTU_W   8'hAE
`define OPC_MLT_H    8'hA2
`define OPC_MLT_W    8'hAA
`define MAC_LOW_BITS 4'h0

// Datapath steps
`define PTR_STEP     32'h0000_0002
`define CNT_STEP     32'h0000_0001
`define REG_NEXT1    4'h1
`define REG_NEXT2    4'h2
`define WMUL_CYCLES  5

// APB register map
`define REG_ALR      12'h000
`define REG_AHR      12'h004
`define REG_STAT     12'h008
`define STAT_OVF_BIT 0
`define STAT_BSY_BIT 1

`endif

/* File: mac_unit_pkg.sv */
package mac_unit_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_CHECK, ST_RD_A, ST_RD_B, ST_DRAIN, ST_WMUL
  } mac_state_t;

  typedef enum logic [2:0] {
    OP_OTHER, OP_MAC, OP_MLT_H, OP_MLTU_H, OP_MLT_W, OP_MLTU_W
  } op_kind_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] insn;
    logic [31:0] opa;
    logic [31:0] opb;
  } issue_t;

  typedef struct packed {
    logic [3:0] cnt_idx;
    logic [3:0] p1_idx;
    logic [3:0] p2_idx;
  } rf_idx_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic [31:0] p1;
    logic [31:0] p2;
  } rf_val_t;

  typedef struct packed {
    logic    we;
    rf_idx_t idx;
    rf_val_t val;
  } rf_wb_t;

  typedef struct packed {
    logic done;
    logic restart;
    logic addr_err;
  } result_t;

  typedef struct packed {
    mac_state_t  st;
    op_kind_t    op;
    logic [2:0]  wcnt;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] cnt;
    logic [31:0] p1;
    logic [31:0] p2;
    logic [15:0] d1;
    logic        acc_pend;
    logic        err;
    logic        restart;
    logic [31:0] alr;
    logic [31:0] ahr;
    logic        ovf;
    logic        busy;
    rf_idx_t     rd_idx;
    rf_wb_t      wb;
    logic        mem_req;
    logic [31:0] mem_addr;
    result_t     res;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mac_regs_t;

endpackage

/* File: core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // Clock
  input  wire logic                  CLK_I,
  // Register file side
  input  wire mac_unit_pkg::rf_idx_t RD_IDX_I,
  output mac_unit_pkg::rf_val_t      RD_VAL_O,
  input  wire mac_unit_pkg::rf_wb_t  WB_I,
  // Halfword memory side
  input  wire logic                  MEM_REQ_I,
  input  wire logic [31:0]           MEM_ADDR_I,
  output logic [15:0]                MEM_RDATA_O
);
  logic [31:0] rf [16];
  logic [15:0] mem [2048];

  initial begin
    MEM_RDATA_O = 16'h0000;
    for (int i = 0; i < 16; i++) rf[i] = 32'h0000_0000;
    for (int i = 0; i < 2048; i++) mem[i] = 16'(i * 37) ^ 16'hA55A;
  end

  assign RD_VAL_O = '{rf[RD_IDX_I.cnt_idx], rf[RD_IDX_I.p1_idx], rf[RD_IDX_I.p2_idx]};

  // Handler keeps count and pointers intact between restarts
  always @(posedge CLK_I) begin
    if (WB_I.we) begin
      rf[WB_I.idx.cnt_idx] <= WB_I.val.cnt;
      rf[WB_I.idx.p1_idx] <= WB_I.val.p1;
      rf[WB_I.idx.p2_idx] <= WB_I.val.p2;
    end
    // No wait states; idle cycles show the inverse so stale data never matches
    MEM_RDATA_O <= MEM_REQ_I ? mem[MEM_ADDR_I[11:1]] : ~MEM_RDATA_O;
  end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                  clk, rst, irq, psel, pen, pwr, pready, pslverr, busy, mem_req, ovf;
  logic                  err;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, alr, ahr, mem_addr, rd, alr0, ahr0;
  logic [15:0]           mem_rdata;
  logic [63:0]           e;
  logic signed [63:0]    prod;
  mac_unit_pkg::issue_t  iss;
  mac_unit_pkg::result_t res, r, res0;
  mac_unit_pkg::rf_idx_t rd_idx;
  mac_unit_pkg::rf_val_t rd_val;
  mac_unit_pkg::rf_wb_t  wb;
  int                    fails, num_checks, cyc;
  int                    nops = 0;
  logic [15:0]           ops [4] = '{16'hA200, 16'hA600, 16'hAA00, 16'hAE00};
  int                    mcyc [4] = '{1, 1, 5, 5};
  logic [63:0]           mexp [4] = '{64'h0000_0000_FFFF_FFFA, 64'h0000_0000_0002_FFFA,
                                      64'hFFFF_FFFF_FFFF_FFFA, 64'h0000_0002_FFFF_FFFA};

  mac_unit #(.HAS_MULT(1)) DUT (
    .CLK_I(clk), .RST_I(rst), .ISSUE_I(iss), .IRQ_PEND_I(irq), .BUSY_O(busy),
    .RESULT_O(res), .RD_IDX_O(rd_idx), .RD_VAL_I(rd_val), .WB_O(wb),
    .MEM_REQ_O(mem_req), .MEM_ADDR_O(mem_addr), .MEM_RDATA_I(mem_rdata),
    .ALR_O(alr), .AHR_O(ahr), .MULTIPLY_OVERFLOW_FLAG_O(ovf),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr)
  );

  // Same instruction stream into a core built without the multiplier
  mac_unit #(.HAS_MULT(0)) DUT_NOMUL (
    .CLK_I(clk), .RST_I(rst), .ISSUE_I(iss), .IRQ_PEND_I(irq), .BUSY_O(),
    .RESULT_O(res0), .RD_IDX_O(), .RD_VAL_I(rd_val), .WB_O(),
    .MEM_REQ_O(), .MEM_ADDR_O(), .MEM_RDATA_I(mem_rdata),
    .ALR_O(alr0), .AHR_O(ahr0), .MULTIPLY_OVERFLOW_FLAG_O(),
    .PSEL_I(1'b0), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(), .PREADY_O(), .PSLVERR_O()
  );

  core_model core (
    .CLK_I(clk), .RD_IDX_I(rd_idx), .RD_VAL_O(rd_val), .WB_I(wb),
    .MEM_REQ_I(mem_req), .MEM_ADDR_I(mem_addr), .MEM_RDATA_O(mem_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (res0.done === 1'b1) begin
      nops <= nops + 1;
    end
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (int k = 0; k <= 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
      if (k == 50) begin
        fails++;
        report_and_stop();
      end
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // Let the edge's updates settle before callers look
    #1;
  endtask

  // Counts edges from the valid cycle until done is seen
  task automatic issue(input logic [15:0] op, input logic [31:0] a, input logic [31:0] b);
    @(posedge clk);
    iss <= '{1'b1, op, a, b};
    cyc = 0;
    do begin
      @(posedge clk);
      iss.valid <= 1'b0;
      #1;
      cyc++;
      if (cyc > 300) begin
        fails++;
        report_and_stop();
      end
    end while (res.done !== 1'b1);
    r = res;
  endtask

  task automatic mac(input logic [3:0] rs, input logic [31:0] n, input logic [31:0] p1,
                     input logic [31:0] p2);
    core.rf[rs] = n;
    core.rf[4'(rs + 1)] = p1;
    core.rf[4'(rs + 2)] = p2;
    e = {ahr, alr};
    // An odd pointer aborts before any accumulate
    if (!p1[0] && !p2[0]) begin
      for (int i = 0; i < n; i++) begin
        prod = $signed(core.mem[p1[11:1] + 11'(i)]) * $signed(core.mem[p2[11:1] + 11'(i)]);
        e = e + prod;
      end
    end
    issue({8'hB2, rs, 4'h0}, 32'h0000_0000, n);
  endtask

  task automatic end_test(input string s);
    $display("test %s finished", s);
  endtask

  initial begin
    rst = 1'b1;
    {irq, psel, pen, pwr, err} = '0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    iss = '0;
    fails = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk({err, rd}, {1'b1, 32'h0000_0000});
    end_test("bus");
    for (int i = 0; i < 4; i++) begin
      issue(ops[i], 32'hFFFF_FFFE, 32'h0000_0003);
      chk({ahr, alr}, mexp[i]);
      chk(cyc, mcyc[i]);
    end
    chk({ahr0, alr0}, 64'h0000_0000_0000_0000);
    chk(nops, 4);
    end_test("multiply");
    apb(1'b1, 12'h004, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h8000_0000);
    chk({ahr, alr}, 64'h0000_0001_8000_0000);
    mac(4'hF, 32'h0000_0003, 32'h0000_0100, 32'h0000_0200);
    chk({ahr, alr}, e);
    chk(cyc, 2 * 3 + 4);
    chk({core.rf[0], core.rf[1]}, {32'h0000_0106, 32'h0000_0206});
    chk(core.rf[15], 32'h0000_0000);
    chk(ovf, 1'b0);
    end_test("mac");
    mac(4'h4, 32'h0000_0000, 32'h0000_0100, 32'h0000_0200);
    chk({ahr, alr}, e);
    chk(cyc, 2 * 0 + 4);
    chk({core.rf[4], core.rf[5]}, {32'h0000_0000, 32'h0000_0100});
    end_test("zero count");
    apb(1'b1, 12'h004, 32'h7FFF_FFFF);
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    chk({ahr, alr}, 64'h7FFF_FFFF_FFFF_FFFF);
    core.mem[11'h180] = 16'h0001;
    mac(4'h6, 32'h0000_0002, 32'h0000_0300, 32'h0000_0300);
    chk({ahr, alr}, e);
    chk({ovf, core.rf[6]}, {1'b1, 32'h0000_0000});
    issue(16'hA200, 32'h0000_0002, 32'h0000_0002);
    chk(ovf, 1'b1);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd[0], 1'b1);
    apb(1'b1, 12'h008, 32'h0000_0001);
    chk(ovf, 1'b0);
    end_test("overflow");
    mac(4'h2, 32'h0000_0002, 32'h0000_0101, 32'h0000_0200);
    chk({r.addr_err, ahr, alr}, {1'b1, e});
    chk(cyc, 4);
    end_test("odd pointer");
    @(posedge clk);
    irq <= 1'b1;
    mac(4'h8, 32'h0000_0002, 32'h0000_0400, 32'h0000_0500);
    chk(r.restart, 1'b1);
    chk({core.rf[8], core.rf[9]}, {32'h0000_0001, 32'h0000_0402});
    @(posedge clk);
    irq <= 1'b0;
    issue(16'hB280, 32'h0000_0000, core.rf[8]);
    chk({r.restart, ahr, alr}, {1'b0, e});
    chk(cyc, 2 * 1 + 4);
    chk(core.rf[8], 32'h0000_0000);
    end_test("interrupt");
    report_and_stop();
  end
endmodule
`default_nettype wire
